// ---- hdl/aoc_defines.vh ----
/*
 * Constants for the alarm output conditioning block: register offsets,
 * field positions, reset values and encodings.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef AOC_DEFINES_VH
`define AOC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define AOC_REG_CTRL      12'h000
`define AOC_REG_POLARITY  12'h004
`define AOC_REG_HYST      12'h008
`define AOC_REG_ALTYPE    12'h00C
`define AOC_REG_STATUS    12'h010
`define AOC_REG_IRQ_STAT  12'h014
`define AOC_REG_IRQ_MASK  12'h018
`define AOC_REG_OUTPUTS   12'h01C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define AOC_CTRL_REARM_BIT     0
`define AOC_CTRL_HBENABLE_BIT  1
`define AOC_CTRL_LATCH_BIT     2
`define AOC_CTRL_RESET         32'h0000_0002

// Standby re-arm choices.
`define AOC_REARM_A            1'b0
`define AOC_REARM_B            1'b1

// Heater hysteresis in units of 0.1 A.
`define AOC_HYST_MIN           10'h001
`define AOC_HYST_MAX           10'h1F4
`define AOC_HYST_RESET         10'h001
`define AOC_HYST_W             10

// Alarm type codes that carry a standby sequence.
`define AOC_TYPE_SB5           4'h5
`define AOC_TYPE_SB6           4'h6
`define AOC_TYPE_SB7           4'h7
`define AOC_TYPE_SB10          4'hA
`define AOC_TYPE_SB11          4'hB

// Interrupt status bit positions.
`define AOC_IRQ_HB_SET         0
`define AOC_IRQ_HB_CLR         1
`define AOC_IRQ_REARM          2
`define AOC_IRQ_W              3

// AXI responses.
`define AOC_RESP_OKAY          2'b00
`define AOC_RESP_SLVERR        2'b10

`endif

// ---- hdl/aoc_pin_sync.v ----
/*
 * Three-stage synchroniser for a group of asynchronous pins.
 * A change is accepted once the second and third stages agree.
 * Assumes the pins are slow relative to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module aoc_pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          pinOut[i] <= 1'b0;
        end else begin
          stage1[i] <= pinIn[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // Only stages two and three are compared; stage one may be metastable.
          if (stage2[i] == stage3[i]) begin
            pinOut[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- hdl/aoc_alarm_output.v ----
/*
 * Alarm and auxiliary output conditioning: standby re-arm, heater alarm
 * latch and hysteresis, forced-off levels, output polarity, indicators,
 * an AXI4-Lite register slave and a level interrupt.
 * Assumes alarm evaluation and level tracking are done on clk elsewhere;
 * key and event-input cancel requests arrive on asynchronous pins.
 */
// Design decisions made here: the AXI4-Lite slave port and the address map.
// Summary of operation
// R1: Standby re-arm applies only to alarm types 5, 6, 7, 10 and 11.
// R2: A control bit selects which events re-arm a released standby sequence.
// R3: Choice A re-arms on start, power-on, alarm value, shift, slope or set-point change.
// R4: Choice A ignores set-point changes caused by the remote set point.
// R5: Choice B re-arms the standby sequence only at power-on.
// R6: Alarm outputs are forced off in setting, communication, advanced, calibration levels.
// R7: Each auxiliary output 1 to 4 has its own polarity bit, close default.
// R8: Close-in-alarm drives the pin with the function state unchanged.
// R9: Open-in-alarm drives the pin with the inverted function state.
// R10: Indicators follow the function state whatever the polarity.
// R11: The heater alarm has an enable which resets to on.
// R12: With latch on, heater alarm holds until 0.0 A, power cycle or cancel.
// R13: With latching in use, initial setting level turns the alarm off.
// R14: Hysteresis 0.1 to 50.0 A, default 0.1, only when enabled and unlatched.
// R15: Polarity is applied after latching and forced-off handling.
// R16: A cancel request is one pulse clearing the latch the next cycle.
`timescale 1ns/100ps
`default_nettype none
`include "aoc_defines.vh"

module aoc_alarm_output #(
  parameter NUM_ALARMS = 4,
  parameter NUM_AUX    = 4,
  parameter CUR_W      = 10
) (
  input  wire                  clk,
  input  wire                  rst_n,
  // AXI4-Lite slave.
  input  wire [11:0]           s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [11:0]           s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Same-clock inputs from alarm evaluation and level tracking.
  input  wire [NUM_ALARMS-1:0] alarmRaw,
  input  wire                  controlStart,
  input  wire                  alarmLimitChange,
  input  wire                  inputShiftChange,
  input  wire                  inputSlopeChange,
  input  wire                  setPointChange,
  input  wire                  remoteSetPointChange,
  input  wire                  levelInitialSetting,
  input  wire                  levelCommSetting,
  input  wire                  levelAdvancedSetting,
  input  wire                  levelCalibration,
  input  wire [CUR_W-1:0]      heaterCurrent,
  input  wire [CUR_W-1:0]      heaterThreshold,
  input  wire [NUM_AUX-1:0]    auxFunctionSelect,
  // Asynchronous cancel pins.
  input  wire                  function_key,
  input  wire                  latch_cancel_function,
  // Outputs.
  output reg  [NUM_ALARMS-1:0] standbyRearm,
  output reg                   heater_break_alarm,
  output reg  [NUM_AUX-1:0]    auxOut,
  output reg  [NUM_AUX-1:0]    aux_indicators,
  output reg                   irq
);

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  function isStandbyType;
    input [3:0] code;
    begin
      isStandbyType = (code == `AOC_TYPE_SB5) || (code == `AOC_TYPE_SB6) ||
                      (code == `AOC_TYPE_SB7) || (code == `AOC_TYPE_SB10) ||
                      (code == `AOC_TYPE_SB11);
    end
  endfunction

  function [CUR_W-1:0] clampHyst;
    input [CUR_W-1:0] v;
    begin
      if (v < `AOC_HYST_MIN) begin
        clampHyst = `AOC_HYST_MIN;
      end else if (v > `AOC_HYST_MAX) begin
        clampHyst = `AOC_HYST_MAX;
      end else begin
        clampHyst = v;
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [31:0]               ctrlReg;
  reg [NUM_AUX-1:0]        polarity;
  reg [CUR_W-1:0]          hystReg;
  reg [4*NUM_ALARMS-1:0]   alarmType;
  reg [`AOC_IRQ_W-1:0]     irqStat;
  reg [`AOC_IRQ_W-1:0]     irqMask;

  wire rearmSelect  = ctrlReg[`AOC_CTRL_REARM_BIT];
  wire hbEnable     = ctrlReg[`AOC_CTRL_HBENABLE_BIT];
  wire latchEnable  = ctrlReg[`AOC_CTRL_LATCH_BIT];

  // --------------------------------------------------------------------
  // Cancel pins
  // --------------------------------------------------------------------
  wire [1:0] cancelLevel;
  reg  [1:0] cancelPrev;
  reg        cancelPulse;

  aoc_pin_sync #(
    .WIDTH (2)
  ) uPinSync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pinIn  ({latch_cancel_function, function_key}),
    .pinOut (cancelLevel)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cancelPrev  <= 2'b00;
      cancelPulse <= 1'b0;
    end else begin
      cancelPrev  <= cancelLevel;
      // A held key yields one pulse per press. [R16]
      cancelPulse <= |(cancelLevel & ~cancelPrev);
    end
  end

  // --------------------------------------------------------------------
  // Power-on marker and standby re-arm
  // --------------------------------------------------------------------
  reg powerOnDone;
  reg [NUM_ALARMS-1:0] next_standbyRearm;
  reg                  rearmEvent;

  always @* begin
    rearmEvent = ~powerOnDone;                                   // [R5]
    if (rearmSelect == `AOC_REARM_A) begin                       // [R2]
      rearmEvent = ~powerOnDone | controlStart | alarmLimitChange |
                   inputShiftChange | inputSlopeChange |
                   (setPointChange & ~remoteSetPointChange);     // [R3] [R4]
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_ALARMS; g = g + 1) begin : gRearm
      always @* begin
        next_standbyRearm[g] = rearmEvent & isStandbyType(alarmType[4*g +: 4]); // [R1]
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Heater alarm with hysteresis and latch
  // --------------------------------------------------------------------
  wire forceOff = levelInitialSetting | levelCommSetting |
                  levelAdvancedSetting | levelCalibration;
  wire [CUR_W:0] releaseLevel = {1'b0, heaterThreshold} + {1'b0, hystReg};
  wire thresholdZero = (heaterThreshold == {CUR_W{1'b0}});
  wire below   = ({1'b0, heaterCurrent} < {1'b0, heaterThreshold});
  wire above   = ({1'b0, heaterCurrent} >= releaseLevel);
  reg  hbState;
  reg  next_hbState;

  always @* begin
    next_hbState = hbState;
    if (!hbEnable || thresholdZero) begin                        // [R11] [R12]
      next_hbState = 1'b0;
    end else if (latchEnable) begin
      if (cancelPulse || levelInitialSetting) begin              // [R12] [R13] [R16]
        next_hbState = 1'b0;
      end else if (below) begin
        next_hbState = 1'b1;
      end
    end else begin
      // Detection band opens at the threshold, closes above it. [R14]
      if (below) begin
        next_hbState = 1'b1;
      end else if (above) begin
        next_hbState = 1'b0;
      end
    end
  end

  // Final alarm state per auxiliary output, polarity applied last. [R15]
  reg [NUM_AUX-1:0] funcState;
  integer k;
  always @* begin
    for (k = 0; k < NUM_AUX; k = k + 1) begin
      if (auxFunctionSelect[k]) begin
        funcState[k] = next_hbState & ~forceOff;                 // [R6]
      end else begin
        funcState[k] = alarmRaw[k % NUM_ALARMS] & ~forceOff;     // [R6]
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerOnDone        <= 1'b0;
      standbyRearm       <= {NUM_ALARMS{1'b0}};
      hbState            <= 1'b0;
      heater_break_alarm <= 1'b0;
      auxOut             <= {NUM_AUX{1'b0}};
      aux_indicators     <= {NUM_AUX{1'b0}};
    end else begin
      powerOnDone        <= 1'b1;
      standbyRearm       <= next_standbyRearm;
      hbState            <= next_hbState;
      heater_break_alarm <= next_hbState & ~forceOff;
      auxOut             <= funcState ^ polarity;                // [R8] [R9]
      aux_indicators     <= funcState;                           // [R10]
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  reg        awHeld;
  reg        wHeld;
  reg [11:0] awAddr;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  wire       doWrite = awHeld & wHeld & ~s_axi_bvalid;
  wire [`AOC_IRQ_W-1:0] irqEvents = {|next_standbyRearm,
                                      hbState & ~next_hbState,
                                      ~hbState & next_hbState};
  reg [`AOC_IRQ_W-1:0] irqClear;

  always @* begin
    irqClear = {`AOC_IRQ_W{1'b0}};
    if (doWrite && awAddr == `AOC_REG_IRQ_STAT && wStrb[0]) begin
      irqClear = wData[`AOC_IRQ_W-1:0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 12'h000;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AOC_RESP_OKAY;
      ctrlReg       <= `AOC_CTRL_RESET;                          // [R11]
      polarity      <= {NUM_AUX{1'b0}};                          // [R7]
      hystReg       <= `AOC_HYST_RESET;                          // [R14]
      alarmType     <= {4*NUM_ALARMS{1'b0}};
      irqStat       <= {`AOC_IRQ_W{1'b0}};
      irqMask       <= {`AOC_IRQ_W{1'b0}};
      irq           <= 1'b0;
    end else begin
      s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `AOC_RESP_OKAY;
        case (awAddr)
          `AOC_REG_CTRL: begin
            if (wStrb[0]) begin
              ctrlReg[7:0] <= wData[7:0];                        // [R2]
            end
          end
          `AOC_REG_POLARITY: begin
            if (wStrb[0]) begin
              polarity <= wData[NUM_AUX-1:0];                    // [R7]
            end
          end
          `AOC_REG_HYST: begin
            if (wStrb[0] && wStrb[1]) begin
              hystReg <= clampHyst(wData[CUR_W-1:0]);            // [R14]
            end
          end
          `AOC_REG_ALTYPE: begin
            if (wStrb[0] && wStrb[1]) begin
              alarmType <= wData[4*NUM_ALARMS-1:0];
            end
          end
          `AOC_REG_IRQ_STAT: begin
          end
          `AOC_REG_IRQ_MASK: begin
            if (wStrb[0]) begin
              irqMask <= wData[`AOC_IRQ_W-1:0];
            end
          end
          default: begin
            s_axi_bresp <= `AOC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // A new event wins over a clear in the same cycle.
      irqStat <= (irqStat & ~irqClear) | irqEvents;
      irq     <= |(((irqStat & ~irqClear) | irqEvents) & irqMask);
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AOC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AOC_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
          `AOC_REG_CTRL:     s_axi_rdata[7:0] <= ctrlReg[7:0];
          `AOC_REG_POLARITY: s_axi_rdata[NUM_AUX-1:0] <= polarity;
          `AOC_REG_HYST:     s_axi_rdata[CUR_W-1:0] <= hystReg;
          `AOC_REG_ALTYPE:   s_axi_rdata[4*NUM_ALARMS-1:0] <= alarmType;
          `AOC_REG_STATUS:   s_axi_rdata[NUM_ALARMS:0] <= {hbState, standbyRearm};
          `AOC_REG_IRQ_STAT: s_axi_rdata[`AOC_IRQ_W-1:0] <= irqStat;
          `AOC_REG_IRQ_MASK: s_axi_rdata[`AOC_IRQ_W-1:0] <= irqMask;
          `AOC_REG_OUTPUTS:  s_axi_rdata[2*NUM_AUX-1:0] <= {aux_indicators, auxOut};
          default:           s_axi_rresp <= `AOC_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- verif/aoc_alarm_output_sva.sv ----
/* Concurrent checks on the ports of the alarm output conditioning block.
   Assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module aoc_alarm_output_sva #(
  parameter NUM_ALARMS = 4,
  parameter NUM_AUX    = 4,
  parameter CUR_W      = 10
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [NUM_ALARMS-1:0] alarmRaw,
  input wire logic                  controlStart,
  input wire logic                  alarmLimitChange,
  input wire logic                  inputShiftChange,
  input wire logic                  inputSlopeChange,
  input wire logic                  setPointChange,
  input wire logic                  remoteSetPointChange,
  input wire logic                  levelInitialSetting,
  input wire logic                  levelCommSetting,
  input wire logic                  levelAdvancedSetting,
  input wire logic                  levelCalibration,
  input wire logic [CUR_W-1:0]      heaterCurrent,
  input wire logic [CUR_W-1:0]      heaterThreshold,
  input wire logic [NUM_AUX-1:0]    auxFunctionSelect,
  input wire logic [NUM_ALARMS-1:0] standbyRearm,
  input wire logic                  heater_break_alarm,
  input wire logic [NUM_AUX-1:0]    auxOut,
  input wire logic [NUM_AUX-1:0]    aux_indicators
);
  // ------------------------------
  // Helpers
  // ------------------------------
  logic [3:0] sinceWr;
  wire logic anyLvl = levelInitialSetting | levelCommSetting | levelAdvancedSetting |
                      levelCalibration;
  wire logic otherCause = controlStart | alarmLimitChange | inputShiftChange | inputSlopeChange;
  wire logic causeA = otherCause | (setPointChange & ~remoteSetPointChange);
  wire logic curLow = heaterCurrent < heaterThreshold;
  wire logic thrZero = heaterThreshold == '0;
  wire logic [NUM_AUX-1:0] rawSel = alarmRaw[NUM_AUX-1:0] & ~auxFunctionSelect;

  // Polarity may only move a few cycles after a register write lands.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      sinceWr <= 4'h0;
    else if (s_axi_wready)
      sinceWr <= 4'h0;
    else if (sinceWr != 4'hF)
      sinceWr <= sinceWr + 4'h1;
  end

  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence lonePulse;
    causeA ##1 !causeA;
  endsequence

  ind_follow_a: assert property (
    $past(rst_n) && !$past(anyLvl) |->
    (aux_indicators & ~$past(auxFunctionSelect)) == $past(rawSel))
    else $error("Indicator does not follow its alarm");
  forced_off_a: assert property (
    $past(rst_n) && $past(anyLvl) |-> aux_indicators == '0 && !heater_break_alarm)
    else $error("Alarm output not forced off in a setting level");
  pol_stable_a: assert property (
    sinceWr > 4'h4 |-> $stable(auxOut ^ aux_indicators))
    else $error("Output polarity changed without a write");
  remote_sp_a: assert property (
    $past(rst_n) && setPointChange && remoteSetPointChange && !otherCause |=>
    standbyRearm == '0)
    else $error("Remote set point re-armed the standby sequence");
  rearm_cause_a: assert property (
    $past(rst_n, 2) && standbyRearm != '0 |-> $past(causeA))
    else $error("Standby re-arm without a cause");
  rearm_pulse_a: assert property (
    $past(rst_n) and lonePulse |=> standbyRearm == '0)
    else $error("Standby re-arm longer than one cycle");
  hb_set_a: assert property (
    $rose(heater_break_alarm) && !$past(anyLvl, 2) |-> $past(curLow))
    else $error("Heater alarm set with current above threshold");
  hb_zero_a: assert property (
    $past(rst_n) && $past(thrZero) |-> !heater_break_alarm)
    else $error("Heater alarm on with zero threshold");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped or changed early");
endmodule

bind aoc_alarm_output aoc_alarm_output_sva #(
  .NUM_ALARMS(NUM_ALARMS), .NUM_AUX(NUM_AUX), .CUR_W(CUR_W)) u_sva (.*);
`default_nettype wire

// ---- verif/aoc_alarm_output_tb.sv ----
/* Self-checking bench for the alarm output conditioning block.
   Assumes a single 200 MHz clock and the AXI4-Lite register map. */
`timescale 1ns/100ps
`default_nettype none
`include "aoc_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errCount++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module aoc_alarm_output_tb;
  typedef struct packed {
    logic [3:0] pol, raw, lvl, aux, ind;
  } aoc_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, alarmRaw, auxFunctionSelect, standbyRearm, auxOut, aux_indicators;
  logic [3:0]  seen, lvl;
  logic [5:0]  ev;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0]  heaterCurrent, heaterThreshold;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, heater_break_alarm;
  logic controlStart, alarmLimitChange, inputShiftChange, inputSlopeChange, setPointChange;
  logic remoteSetPointChange, levelInitialSetting, levelCommSetting, levelAdvancedSetting;
  logic levelCalibration, function_key, latch_cancel_function;
  int   errCount = 0;
  int   comparisons = 0;
  int   i, j;
  aoc_row_t rows[7] = '{'{4'h0, 4'hA, 4'h0, 4'hA, 4'hA}, '{4'hF, 4'hA, 4'h0, 4'h5, 4'hA},
                        '{4'h6, 4'h3, 4'h0, 4'h5, 4'h3}, '{4'hF, 4'hF, 4'h1, 4'hF, 4'h0},
                        '{4'h0, 4'hF, 4'h2, 4'h0, 4'h0}, '{4'hA, 4'hF, 4'h4, 4'hA, 4'h0},
                        '{4'h5, 4'hF, 4'h8, 4'h5, 4'h0}};
  logic [3:0] types[7] = '{`AOC_TYPE_SB5, `AOC_TYPE_SB6, `AOC_TYPE_SB7, `AOC_TYPE_SB10,
                           `AOC_TYPE_SB11, 4'h4, 4'h0};
  logic [5:0] causes[6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h30};

  assign {remoteSetPointChange, setPointChange, inputSlopeChange, inputShiftChange,
          alarmLimitChange, controlStart} = ev;
  assign {levelCalibration, levelAdvancedSetting, levelCommSetting, levelInitialSetting} = lvl;

  aoc_alarm_output u_aoc_alarm_output (.*);

  always #2.5 clk = ~clk;

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic summarize();
    if (errCount == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic hang();
    errCount++;
    summarize();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ready is raised late on purpose so the slave must hold its answer.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n >= 4 && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) hang();
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n >= 3 && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) hang();
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    axi_rd(a);
    `CHK(rd, e)
  endtask

  // Re-arm is a single-cycle pulse, so it is gathered over a short window.
  task automatic pulse(input logic [5:0] m, input logic [3:0] e);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
    seen = 4'h0;
    repeat (3) begin
      #1 seen |= standbyRearm;
      @(posedge clk);
    end
    `CHK(seen, e)
  endtask

  task automatic hb(input logic [9:0] c, input logic e);
    heaterCurrent <= c;
    tick(4);
    `CHK(heater_break_alarm, e)
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {alarmRaw, auxFunctionSelect, lvl, ev, heaterCurrent, heaterThreshold} = '0;
    {function_key, latch_cancel_function} = 2'h0;
    tick(2);
    rst_n <= 1'b1;
    rd_chk(`AOC_REG_CTRL, `AOC_CTRL_RESET);
    rd_chk(`AOC_REG_POLARITY, 32'h0000_0000);
    rd_chk(`AOC_REG_HYST, {22'h0, `AOC_HYST_RESET});
    rd_chk(`AOC_REG_ALTYPE, 32'h0000_0000);
    `CHK(rsp, `AOC_RESP_OKAY)
    axi_rd(12'h020);
    `CHK({rsp, rd}, {`AOC_RESP_SLVERR, 32'h0000_0000})
    axi_wr(12'h020, 32'h0000_000F);
    `CHK(rsp, `AOC_RESP_SLVERR)
    for (i = 0; i < 7; i++) begin
      axi_wr(`AOC_REG_POLARITY, {28'h0, rows[i].pol});
      alarmRaw <= rows[i].raw;
      lvl      <= rows[i].lvl;
      tick(3);
      `CHK(auxOut, rows[i].aux)
      `CHK(aux_indicators, rows[i].ind)
    end
    lvl <= 4'h0;
    for (i = 0; i < 7; i++) begin
      axi_wr(`AOC_REG_ALTYPE, {16'h0, {4{types[i]}}});
      pulse(6'h01, (i < 5) ? 4'hF : 4'h0);
    end
    axi_wr(`AOC_REG_ALTYPE, 32'h0000_BA75);
    for (j = 0; j < 2; j++) begin
      axi_wr(`AOC_REG_CTRL, (j == 0) ? 32'h0000_0002 : 32'h0000_0003);
      for (i = 0; i < 6; i++)
        pulse(causes[i], (i < 5 && j == 0) ? 4'hF : 4'h0);
    end
    axi_wr(`AOC_REG_IRQ_MASK, 32'h0000_0004);
    tick(2);
    `CHK(irq, 1'b1)
    axi_wr(`AOC_REG_IRQ_STAT, 32'h0000_0004);
    tick(2);
    `CHK(irq, 1'b0)
    auxFunctionSelect <= 4'h1;
    heaterThreshold   <= 10'h064;
    hb(10'h032, 1'b1);
    `CHK(aux_indicators[0], 1'b1)
    hb(10'h064, 1'b1);
    hb(10'h065, 1'b0);
    axi_wr(`AOC_REG_HYST, 32'h0000_03FF);
    rd_chk(`AOC_REG_HYST, 32'h0000_01F4);
    s_axi_wstrb <= 4'h1;
    axi_wr(`AOC_REG_HYST, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rd_chk(`AOC_REG_HYST, 32'h0000_01F4);
    axi_wr(`AOC_REG_HYST, 32'h0000_0000);
    rd_chk(`AOC_REG_HYST, 32'h0000_0001);
    axi_wr(`AOC_REG_HYST, 32'h0000_0014);
    hb(10'h032, 1'b1);
    hb(10'h077, 1'b1);
    hb(10'h078, 1'b0);
    axi_wr(`AOC_REG_CTRL, 32'h0000_0000);
    hb(10'h032, 1'b0);
    axi_wr(`AOC_REG_CTRL, 32'h0000_0006);
    for (i = 0; i < 4; i++) begin
      hb(10'h032, 1'b1);
      hb(10'h0C8, 1'b1);
      case (i)
        0: function_key <= 1'b1;
        1: latch_cancel_function <= 1'b1;
        2: heaterThreshold <= 10'h000;
        default: lvl <= 4'h1;
      endcase
      tick(8);
      {function_key, latch_cancel_function} <= 2'h0;
      lvl <= 4'h0;
      heaterThreshold <= 10'h064;
      hb(10'h0C8, 1'b0);
    end
    hb(10'h032, 1'b1);
    hb(10'h0C8, 1'b1);
    rst_n <= 1'b0;
    tick(2);
    `CHK({auxOut, aux_indicators, standbyRearm, heater_break_alarm, irq}, 14'h0000)
    rst_n <= 1'b1;
    hb(10'h0C8, 1'b0);
    rd_chk(`AOC_REG_CTRL, `AOC_CTRL_RESET);
    rd_chk(`AOC_REG_POLARITY, 32'h0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
